// *** hw/bmf_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: A set sense select bit in the upper nibble makes that channel's sense result 16-bit signed.
// RQ2: Bits 7..4 pick sense range for channels 1..4: clear 0..+100 mV unsigned, set -100..+100 mV.
// RQ3: Bits 3..0 pick bus range for channels 1..4: clear 0..+32 V unsigned, set -32..+32 V signed.
// RQ4: If either select of a channel is set, its power result is given in two's complement.
module bmf_top #(
	parameter logic [6:0] DEV_ADDR = bmf_pkg::DEFAULT_DEV_ADDR
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic sample_valid_i,
	input wire logic [bmf_pkg::NUM_CH*bmf_pkg::RAW_W-1:0] sense_raw_i,
	input wire logic [bmf_pkg::NUM_CH*bmf_pkg::RAW_W-1:0] bus_raw_i,
	output logic [bmf_pkg::NUM_CH*bmf_pkg::CODE_W-1:0] sense_code_o,
	output logic [bmf_pkg::NUM_CH*bmf_pkg::CODE_W-1:0] bus_code_o,
	output logic [bmf_pkg::NUM_CH*bmf_pkg::POWER_W-1:0] power_o,
	output logic [bmf_pkg::NUM_CH-1:0] power_signed_o,
	output logic sample_valid_o
);
	import bmf_pkg::*;

	bmf_state_t state_q;
	bmf_state_t state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] shreg_q;
	logic [7:0] shreg_d;
	logic [1:0] byte_q;
	logic [1:0] byte_d;
	logic rw_q;
	logic rw_d;
	logic nack_q;
	logic nack_d;
	logic [7:0] ptr_q;
	logic [7:0] ptr_d;
	logic [7:0] pol_q;
	logic [7:0] pol_d;
	logic oe_n_q;
	logic oe_n_d;
	logic scl_q;
	logic sda_q;
	logic valid_q;

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] rd_data;

	// pins are synchronous; one stage of history is enough for edges
	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_seen = scl_i & scl_q & ~sda_q & sda_i;
	assign rd_data = (ptr_q == POLARITY_REG_ADDR) ? pol_q : UNMAPPED_READ_VALUE;

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		shreg_d = shreg_q;
		byte_d = byte_q;
		rw_d = rw_q;
		nack_d = nack_q;
		ptr_d = ptr_q;
		pol_d = pol_q;
		oe_n_d = oe_n_q;
		if (stop_seen)
		begin
			state_d = ST_IDLE;
			oe_n_d = 1'b1;
		end
		else if (start_seen)
		begin
			// repeated start keeps the pointer for a following read
			state_d = ST_RX;
			cnt_d = '0;
			byte_d = BYTE_ADDR;
			oe_n_d = 1'b1;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					oe_n_d = 1'b1;
				end
				ST_RX:
				begin
					if (scl_rise && cnt_q != BITS_PER_BYTE)
					begin
						shreg_d = {shreg_q[6:0], sda_i};
						cnt_d = cnt_q + 4'h1;
					end
					else if (scl_fall && cnt_q == BITS_PER_BYTE)
					begin
						cnt_d = '0;
						oe_n_d = 1'b0;
						state_d = ST_ACK;
						if (byte_q == BYTE_ADDR)
						begin
							rw_d = shreg_q[0];
							byte_d = BYTE_POINTER;
							if (shreg_q[7:1] != DEV_ADDR)
							begin
								oe_n_d = 1'b1;
								state_d = ST_IDLE;
							end
						end
						else if (byte_q == BYTE_POINTER)
						begin
							ptr_d = shreg_q;
							byte_d = BYTE_DATA;
						end
						else if (ptr_q == POLARITY_REG_ADDR)
						begin
							pol_d = shreg_q; // see RQ2 // see RQ3
						end
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						if (rw_q)
						begin
							shreg_d = rd_data;
							oe_n_d = rd_data[7];
							state_d = ST_TX;
						end
						else
						begin
							oe_n_d = 1'b1;
							state_d = ST_RX;
						end
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						cnt_d = cnt_q + 4'h1;
						shreg_d = {shreg_q[6:0], 1'b0};
						if (cnt_q == BITS_PER_BYTE - 4'h1)
						begin
							oe_n_d = 1'b1;
							nack_d = 1'b0;
							state_d = ST_TXACK;
						end
						else
						begin
							oe_n_d = shreg_q[6];
						end
					end
				end
				ST_TXACK:
				begin
					if (scl_rise)
						nack_d = sda_i;
					else if (scl_fall)
					begin
						cnt_d = '0;
						if (nack_q)
							state_d = ST_IDLE;
						else
						begin
							// no pointer advance: repeated reads return the same byte
							shreg_d = rd_data;
							oe_n_d = rd_data[7];
							state_d = ST_TX;
						end
					end
				end
				default:
				begin
					state_d = ST_IDLE;
					oe_n_d = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			shreg_q <= '0;
			byte_q <= BYTE_ADDR;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			ptr_q <= '0;
			pol_q <= POLARITY_REG_RESET;
			oe_n_q <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_o <= 1'b0;
			valid_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shreg_q <= shreg_d;
			byte_q <= byte_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			ptr_q <= ptr_d;
			pol_q <= pol_d;
			oe_n_q <= oe_n_d;
			scl_q <= scl_i;
			sda_q <= sda_i;
			sda_o <= 1'b0;
			valid_q <= sample_valid_i;
		end
	end

	assign sda_oe_n_o = oe_n_q;
	assign sample_valid_o = valid_q;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++)
		begin : g_ch
			// channel 1 owns the highest bit of each nibble
			bmf_channel_fmt u_fmt (
				.ref_clk_i(ref_clk_i),
				.rstn_i(rstn_i),
				.sample_valid_i(sample_valid_i),
				.sense_signed_i(pol_q[SENSE_FIELD_MSB-ch]), // see RQ1
				.bus_signed_i(pol_q[BUS_FIELD_MSB-ch]), // see RQ3
				.sense_raw_i(sense_raw_i[ch*RAW_W +: RAW_W]),
				.bus_raw_i(bus_raw_i[ch*RAW_W +: RAW_W]),
				.sense_code_o(sense_code_o[ch*CODE_W +: CODE_W]),
				.bus_code_o(bus_code_o[ch*CODE_W +: CODE_W]),
				.power_o(power_o[ch*POWER_W +: POWER_W]),
				.power_signed_o(power_signed_o[ch])
			);
		end
	endgenerate

endmodule

// *** hw/bmf_pkg.sv ***
package bmf_pkg;

	localparam int NUM_CH = 4;
	localparam int RAW_W = 17;
	localparam int CODE_W = 16;
	localparam int POWER_W = 32;

	localparam logic [7:0] POLARITY_REG_ADDR = 8'h1D;
	localparam logic [7:0] POLARITY_REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
	localparam int SENSE_FIELD_MSB = 7;
	localparam int BUS_FIELD_MSB = 3;

	// bus address of the device; the value is arbitrary
	localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2A;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_POINTER = 2'h1;
	localparam logic [1:0] BYTE_DATA = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_TXACK = 3'b100
	} bmf_state_t;

endpackage

// *** hw/bmf_channel_fmt.sv ***
`timescale 1ns/1ps
module bmf_channel_fmt (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic sample_valid_i,
	input wire logic sense_signed_i,
	input wire logic bus_signed_i,
	input wire logic signed [bmf_pkg::RAW_W-1:0] sense_raw_i,
	input wire logic signed [bmf_pkg::RAW_W-1:0] bus_raw_i,
	output logic [bmf_pkg::CODE_W-1:0] sense_code_o,
	output logic [bmf_pkg::CODE_W-1:0] bus_code_o,
	output logic [bmf_pkg::POWER_W-1:0] power_o,
	output logic power_signed_o
);
	import bmf_pkg::*;

	logic [CODE_W-1:0] sense_d;
	logic [CODE_W-1:0] bus_d;
	logic [POWER_W-1:0] power_d;
	logic psign_d;
	logic signed [RAW_W-1:0] sense_op;
	logic signed [RAW_W-1:0] bus_op;
	logic signed [2*RAW_W-1:0] prod;

	// raw input spans twice full scale; unipolar clips negatives to zero
	function automatic logic [CODE_W-1:0] fmt(input logic sgn, input logic signed [RAW_W-1:0] x);
		logic [CODE_W-1:0] r;
		r = '0;
		if (sgn)
			r = x[RAW_W-1:1];
		else if (!x[RAW_W-1])
			r = x[CODE_W-1:0];
		return r;
	endfunction

	always_comb
	begin
		sense_d = fmt(sense_signed_i, sense_raw_i); // see RQ1 // see RQ2
		bus_d = fmt(bus_signed_i, bus_raw_i); // see RQ3
		psign_d = sense_signed_i | bus_signed_i; // see RQ4
		sense_op = sense_signed_i ? {{1{sense_d[CODE_W-1]}}, sense_d} : {1'b0, sense_d};
		bus_op = bus_signed_i ? {{1{bus_d[CODE_W-1]}}, bus_d} : {1'b0, bus_d};
		prod = sense_op * bus_op;
		// unsigned product fits 32 bits; signed one fits too, using all 32 bits when only one operand is signed
		power_d = prod[POWER_W-1:0]; // see RQ4
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sense_code_o <= '0;
			bus_code_o <= '0;
			power_o <= '0;
			power_signed_o <= 1'b0;
		end
		else if (sample_valid_i)
		begin
			sense_code_o <= sense_d;
			bus_code_o <= bus_d;
			power_o <= power_d;
			power_signed_o <= psign_d;
		end
	end

endmodule

// *** bench/bmf_top_sva.sv ***
`timescale 1ns/1ps
module bmf_top_sva (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic sample_valid_i,
	input wire logic [67:0] sense_raw_i,
	input wire logic [67:0] bus_raw_i,
	input wire logic [63:0] sense_code_o,
	input wire logic [63:0] bus_code_o,
	input wire logic [127:0] power_o,
	input wire logic [3:0] power_signed_o,
	input wire logic sample_valid_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_ch1_plain;
		sample_valid_i ##1 !power_signed_o[0];
	endsequence
	a_strobe_follow: assert property (sample_valid_i |=> sample_valid_o)
		else $error("result strobe missing");
	a_result_hold: assert property (!sample_valid_i |=> !sample_valid_o &&
		$stable({sense_code_o, bus_code_o, power_o, power_signed_o}))
		else $error("results moved without a sample");
	a_sense_clip: assert property (s_ch1_plain |-> sense_code_o[15:0] ==
		($past(sense_raw_i[16]) ? 16'h0000 : $past(sense_raw_i[15:0])))
		else $error("unsigned sense code wrong");
	a_bus_clip: assert property (sample_valid_i ##1 !power_signed_o[3] |->
		bus_code_o[63:48] == ($past(bus_raw_i[67]) ? 16'h0000 : $past(bus_raw_i[66:51])))
		else $error("unsigned bus code wrong");
	a_power_plain: assert property (!power_signed_o[2] |-> power_o[95:64] ==
		{16'h0000, sense_code_o[47:32]} * {16'h0000, bus_code_o[47:32]})
		else $error("unsigned power wrong");
	// data may only move while the bus clock is low
	a_sda_low_scl: assert property ($changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i))
		else $error("sda moved with scl high");
endmodule
bind bmf_top bmf_top_sva i_sva (.*);

// *** bench/bmf_host.sv ***
`timescale 1ns/1ps
module bmf_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o = 1'b1,
	output logic sda_o = 1'b1
);
	task automatic hold();
		repeat (4) @(negedge clk_i);
	endtask
	// sda is raised before scl so a repeated start never reads as a stop
	task automatic start();
		sda_o = 1'b1;
		hold();
		scl_o = 1'b1;
		hold();
		sda_o = 1'b0;
		hold();
		scl_o = 1'b0;
	endtask
	task automatic stop();
		hold();
		sda_o = 1'b0;
		hold();
		scl_o = 1'b1;
		hold();
		sda_o = 1'b1;
		hold();
	endtask
	// nine clocks; a 1 in tx releases the line
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
		begin
			hold();
			sda_o = tx[i];
			hold();
			scl_o = 1'b1;
			hold();
			rx[i] = sda_i;
			scl_o = 1'b0;
		end
	endtask
endmodule

// *** bench/bmf_top_tb.sv ***
`timescale 1ns/1ps
module bmf_top_tb;
	import bmf_pkg::*;
	logic ref_clk_i, rstn_i, scl_i, h_sda, sda_o, sda_oe_n_o, sample_valid_i, sample_valid_o;
	logic [67:0] sense_raw_i, bus_raw_i;
	logic [63:0] sense_code_o, bus_code_o;
	logic [127:0] power_o;
	logic [3:0] power_signed_o;
	logic [259:0] exq[$];
	// last entry is lopsided so a swapped channel order in the power sign shows
	logic [7:0] sel[5] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h38};
	logic [31:0] seed = 32'hC7BB;
	int err_total = 0;
	int tests_run = 0;
	wire sda_i = h_sda & (sda_oe_n_o | sda_o);
	wire [259:0] outs = {sense_code_o, bus_code_o, power_o, power_signed_o};
	bmf_top i_bmf_top (.*);
	bmf_host i_bmf_host (.clk_i(ref_clk_i), .sda_i, .scl_o(scl_i), .sda_o(h_sda));
	initial
	begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input string n, input logic [259:0] e, input logic [259:0] g);
		tests_run++;
		if (e !== g)
		begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic final_report();
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic logic [259:0] model(input logic [7:0] r, input logic [67:0] s,
		input logic [67:0] b);
		logic [63:0] sc;
		logic [63:0] bc;
		logic [127:0] p;
		logic [3:0] ps;
		for (int c = 0; c < 4; c++)
		begin
			sc[c*16+:16] = r[7-c] ? s[c*17+1+:16] : (s[c*17+16] ? 16'h0000 : s[c*17+:16]);
			bc[c*16+:16] = r[3-c] ? b[c*17+1+:16] : (b[c*17+16] ? 16'h0000 : b[c*17+:16]);
			p[c*32+:32] = {{16{r[7-c] & sc[c*16+15]}}, sc[c*16+:16]} *
				{{16{r[3-c] & bc[c*16+15]}}, bc[c*16+:16]};
			ps[c] = r[7-c] | r[3-c];
		end
		return {sc, bc, p, ps};
	endfunction
	task automatic put(input logic [7:0] v);
		logic [8:0] rx;
		i_bmf_host.xfer({v, 1'b1}, rx);
		chk("ack", 1'b0, rx[0]);
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		logic [8:0] rx;
		i_bmf_host.start();
		put({DEFAULT_DEV_ADDR, 1'b0});
		put(p);
		i_bmf_host.start();
		put({DEFAULT_DEV_ADDR, 1'b1});
		i_bmf_host.xfer(9'h1FF, rx);
		chk("reg", e, rx[8:1]);
		i_bmf_host.stop();
	endtask
	always @(negedge ref_clk_i)
		if (sample_valid_o === 1'b1)
			chk("sample", exq.size() ? exq.pop_front() : 'x, outs);
	initial
	begin
		logic [8:0] rx;
		rstn_i = 1'b0;
		sample_valid_i = 1'b0;
		sense_raw_i = '0;
		bus_raw_i = '0;
		repeat (2) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		rd(8'h1D, 8'h00);
		rd(8'h1C, 8'h00);
		foreach (sel[i])
		begin
			i_bmf_host.start();
			put({DEFAULT_DEV_ADDR, 1'b0});
			put(8'h1D);
			put(sel[i]);
			i_bmf_host.stop();
			rd(8'h1D, sel[i]);
			// back to back samples catch a stale select or result
			repeat (4)
			begin
				seed = lfsr(lfsr(seed));
				sense_raw_i = {seed, lfsr(seed), seed[3:0]};
				bus_raw_i = {lfsr(seed), seed, seed[7:4]};
				sample_valid_i = 1'b1;
				exq.push_back(model(sel[i], sense_raw_i, bus_raw_i));
				@(negedge ref_clk_i);
			end
			sample_valid_i = 1'b0;
		end
		repeat (4) @(negedge ref_clk_i);
		chk("left", 0, exq.size());
		// wrong address: no ack, and the bytes after it must not reach the register
		i_bmf_host.start();
		i_bmf_host.xfer({DEFAULT_DEV_ADDR ^ 7'h01, 1'b0, 1'b1}, rx);
		chk("nack", 1'b1, rx[0]);
		i_bmf_host.xfer({POLARITY_REG_ADDR, 1'b1}, rx);
		i_bmf_host.xfer({8'h00, 1'b1}, rx);
		i_bmf_host.stop();
		rd(8'h1D, sel[4]);
		// mid-run reset clears the select and every result
		rstn_i = 1'b0;
		@(negedge ref_clk_i);
		rstn_i = 1'b1;
		chk("rst", 0, outs);
		rd(8'h1D, POLARITY_REG_RESET);
		final_report();
	end
	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		err_total++;
		final_report();
	end
endmodule
